/* File: logic/ckgpm_pkg.sv */
package ckgpm_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CKGPM_SYS_CLK_ENABLE = 8'h00;
  localparam logic [7:0] CKGPM_SYS_CLK_DISABLE = 8'h04;
  localparam logic [7:0] CKGPM_SYS_CLK_STATUS = 8'h08;
  localparam logic [7:0] CKGPM_PERIPH_CLK_ENABLE = 8'h10;
  localparam logic [7:0] CKGPM_PERIPH_CLK_DISABLE = 8'h14;
  localparam logic [7:0] CKGPM_PERIPH_CLK_STATUS = 8'h18;
  localparam logic [7:0] CKGPM_MAIN_OSC_CONTROL = 8'h20;
  localparam logic [7:0] CKGPM_MAIN_CLK_FREQUENCY = 8'h24;
  localparam logic [7:0] CKGPM_PLL_CONFIGURATION = 8'h2c;
  localparam logic [7:0] CKGPM_STATUS = 8'h68;

  // ==========================================================
  // System clock enable/disable/status bit positions
  localparam int CKGPM_PROC_CLK_POS = 0;
  localparam int CKGPM_USB_CLK_POS = 7;
  localparam int CKGPM_PROG_CLK_LSB = 8;
  localparam int CKGPM_PROG_CLK_NUM = 3;

  // ==========================================================
  // Main oscillator control fields
  localparam int CKGPM_OSC_ENABLE_POS = 0;
  localparam int CKGPM_OSC_BYPASS_POS = 1;
  localparam int CKGPM_OSC_COUNT_LSB = 8;
  localparam int CKGPM_OSC_COUNT_W = 8;
  localparam int CKGPM_OSC_COUNT_SCALE = 8;

  // ==========================================================
  // Main clock frequency fields
  localparam int CKGPM_FREQ_COUNT_W = 16;
  localparam int CKGPM_FREQ_VALID_POS = 16;
  localparam int CKGPM_FREQ_WINDOW = 16;

  // ==========================================================
  // PLL configuration fields
  localparam int CKGPM_PLL_DIV_LSB = 0;
  localparam int CKGPM_PLL_DIV_W = 8;
  localparam int CKGPM_PLL_CNT_LSB = 8;
  localparam int CKGPM_PLL_CNT_W = 6;
  localparam int CKGPM_PLL_RANGE_LSB = 14;
  localparam int CKGPM_PLL_RANGE_W = 2;
  localparam int CKGPM_PLL_MUL_LSB = 16;
  localparam int CKGPM_PLL_MUL_W = 11;
  localparam int CKGPM_PLL_USB_LSB = 28;
  localparam int CKGPM_PLL_USB_W = 2;
  localparam logic [1:0] CKGPM_USB_DIV_RESERVED = 2'h3;

  // ==========================================================
  // Status register bits
  localparam int CKGPM_SR_OSC_STABLE_POS = 0;
  localparam int CKGPM_SR_LOCK_POS = 2;
  localparam int CKGPM_SR_MCK_READY_POS = 3;

  // ==========================================================
  // Reset values and default implemented-peripheral mask
  localparam logic [31:0] CKGPM_SYS_CLK_RESET = 32'h0000_0001;
  localparam logic [31:0] CKGPM_PLL_RESET = 32'h0000_3f00;
  localparam logic [31:0] CKGPM_MOR_RESET = 32'h0000_0000;
  localparam logic [31:0] CKGPM_PERIPH_IMPL_DEFAULT = 32'hffff_fffc;

  // ==========================================================
  // Oscillator state
  typedef enum logic [3:0] {
    CKGPM_OSC_OFF = 4'b0001,
    CKGPM_OSC_START = 4'b0010,
    CKGPM_OSC_RUN = 4'b0100,
    CKGPM_OSC_BYP = 4'b1000
  } ckgpm_osc_state_t;

endpackage : ckgpm_pkg

/* File: logic/ckgpm_top.sv */
`timescale 1ns/100ps
module ckgpm_top
  import ckgpm_pkg::*;
#(
  parameter logic [31:0] PERIPH_IMPL = CKGPM_PERIPH_IMPL_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Timing references
  input wire logic slow_clk_i,
  input wire logic main_clk_i,
  // Clock gate controls
  output logic proc_clk_en_o,
  output logic usb_port_clock_signal_en_o,
  output logic [CKGPM_PROG_CLK_NUM-1:0] prog_clk_en_o,
  output logic [31:0] periph_clk_en_o,
  // Oscillator controls
  output logic main_osc_enable_o,
  output logic osc_bypass_sel_o,
  output logic main_osc_stable_flag_o,
  // PLL controls
  output logic [CKGPM_PLL_DIV_W-1:0] pll_in_div_o,
  output logic pll_in_div_off_o,
  output logic [CKGPM_PLL_MUL_W-1:0] pll_freq_factor_o,
  output logic pll_active_o,
  output logic [CKGPM_PLL_RANGE_W-1:0] pll_range_o,
  output logic [CKGPM_PLL_USB_W-1:0] usb_clock_divider_o,
  output logic pll_locked_o
);

  // ==========================================================
  // Elaboration check
  if (PERIPH_IMPL[1:0] != 2'h0) begin : g_bad_impl
    $error("Peripheral bits 0 and 1 cannot be implemented");
  end
  if (CKGPM_OSC_COUNT_SCALE != 8) begin : g_bad_scale
    $error("Start-up scale must be eight, the timer shifts by three");
  end
  if (CKGPM_FREQ_WINDOW < 1 || CKGPM_FREQ_WINDOW > 32) begin : g_bad_window
    $error("Frequency window must fit the five-bit period counter");
  end
  if (CKGPM_PROG_CLK_LSB + CKGPM_PROG_CLK_NUM > 32) begin : g_bad_prog
    $error("Programmable clock bits must fit the status word");
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] ckgpm_lanes(input logic [31:0] d, input logic [3:0] s);
    ckgpm_lanes = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : ckgpm_lanes

  // Write strobe for one register offset
  function automatic logic ckgpm_hit(input logic w, input logic [7:0] a, input logic [7:0] o);
    ckgpm_hit = w && (a == o);
  endfunction : ckgpm_hit

  // ==========================================================
  // Bus decode
  logic access;
  logic wr;
  logic [31:0] wdat;
  logic slow_prev;
  logic main_prev;
  logic slow_tick;
  logic main_tick;

  assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = access && wb_we_i;
  assign wdat = ckgpm_lanes(wb_dat_i, wb_sel_i);
  assign slow_tick = slow_clk_i && !slow_prev;
  assign main_tick = main_clk_i && !main_prev;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Follow the pins in reset, else a high pin reads as an edge after it
      slow_prev <= slow_clk_i;
      main_prev <= main_clk_i;
    end else begin
      slow_prev <= slow_clk_i;
      main_prev <= main_clk_i;
    end
  end

  // ==========================================================
  // System clock enables
  logic [CKGPM_PROG_CLK_NUM-1:0] prog_set;
  logic [CKGPM_PROG_CLK_NUM-1:0] prog_clr;
  assign prog_set = wdat[CKGPM_PROG_CLK_LSB +: CKGPM_PROG_CLK_NUM];
  assign prog_clr = wdat[CKGPM_PROG_CLK_LSB +: CKGPM_PROG_CLK_NUM];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      proc_clk_en_o <= CKGPM_SYS_CLK_RESET[CKGPM_PROC_CLK_POS];
      usb_port_clock_signal_en_o <= CKGPM_SYS_CLK_RESET[CKGPM_USB_CLK_POS];
      prog_clk_en_o <= CKGPM_SYS_CLK_RESET[CKGPM_PROG_CLK_LSB +: CKGPM_PROG_CLK_NUM];
    end else if (ckgpm_hit(wr, wb_adr_i, CKGPM_SYS_CLK_ENABLE)) begin
      if (wdat[CKGPM_PROC_CLK_POS]) begin
        proc_clk_en_o <= 1'b1;
      end
      if (wdat[CKGPM_USB_CLK_POS]) begin
        usb_port_clock_signal_en_o <= 1'b1;
      end
      prog_clk_en_o <= prog_clk_en_o | prog_set;
    end else if (ckgpm_hit(wr, wb_adr_i, CKGPM_SYS_CLK_DISABLE)) begin
      if (wdat[CKGPM_PROC_CLK_POS]) begin
        proc_clk_en_o <= 1'b0;
      end
      if (wdat[CKGPM_USB_CLK_POS]) begin
        usb_port_clock_signal_en_o <= 1'b0;
      end
      prog_clk_en_o <= prog_clk_en_o & ~prog_clr;
    end
  end

  // ==========================================================
  // Peripheral clock enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_clk_en_o <= 32'h0000_0000;
    end else if (ckgpm_hit(wr, wb_adr_i, CKGPM_PERIPH_CLK_ENABLE)) begin
      periph_clk_en_o <= periph_clk_en_o | (wdat & PERIPH_IMPL);
    end else if (ckgpm_hit(wr, wb_adr_i, CKGPM_PERIPH_CLK_DISABLE)) begin
      periph_clk_en_o <= periph_clk_en_o & ~(wdat & PERIPH_IMPL);
    end
  end

  // ==========================================================
  // Main oscillator control register
  logic [CKGPM_OSC_COUNT_W-1:0] osc_count;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_osc_enable_o <= CKGPM_MOR_RESET[CKGPM_OSC_ENABLE_POS];
      osc_bypass_sel_o <= CKGPM_MOR_RESET[CKGPM_OSC_BYPASS_POS];
      osc_count <= CKGPM_MOR_RESET[CKGPM_OSC_COUNT_LSB +: CKGPM_OSC_COUNT_W];
    end else if (ckgpm_hit(wr, wb_adr_i, CKGPM_MAIN_OSC_CONTROL)) begin
      main_osc_enable_o <= wdat[CKGPM_OSC_ENABLE_POS];
      osc_bypass_sel_o <= wdat[CKGPM_OSC_BYPASS_POS];
      osc_count <= wdat[CKGPM_OSC_COUNT_LSB +: CKGPM_OSC_COUNT_W];
    end
  end

  // ==========================================================
  // Oscillator start-up
  // Bypass wins if software breaks the exclusive rule
  ckgpm_osc_state_t osc_state;
  logic [CKGPM_OSC_COUNT_W+2:0] osc_timer;
  logic [CKGPM_OSC_COUNT_W+2:0] osc_target;
  assign osc_target = {osc_count, 3'h0};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_state <= CKGPM_OSC_OFF;
      osc_timer <= '0;
    end else begin
      case (osc_state)
        CKGPM_OSC_OFF: begin
          osc_timer <= '0;
          if (osc_bypass_sel_o) begin
            osc_state <= CKGPM_OSC_BYP;
          end else if (main_osc_enable_o) begin
            osc_state <= CKGPM_OSC_START;
          end
        end
        CKGPM_OSC_START: begin
          if (osc_bypass_sel_o) begin
            osc_state <= CKGPM_OSC_BYP;
          end else if (!main_osc_enable_o) begin
            osc_state <= CKGPM_OSC_OFF;
          end else if (osc_timer >= osc_target) begin
            osc_state <= CKGPM_OSC_RUN;
          end else if (slow_tick) begin
            osc_timer <= osc_timer + 1'b1;
          end
        end
        CKGPM_OSC_RUN: begin
          if (osc_bypass_sel_o) begin
            osc_state <= CKGPM_OSC_BYP;
          end else if (!main_osc_enable_o) begin
            osc_state <= CKGPM_OSC_OFF;
          end
        end
        CKGPM_OSC_BYP: begin
          if (!osc_bypass_sel_o) begin
            osc_state <= CKGPM_OSC_OFF;
          end
        end
        default: begin
          osc_state <= CKGPM_OSC_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_osc_stable_flag_o <= 1'b0;
    end else begin
      main_osc_stable_flag_o <= (osc_state == CKGPM_OSC_RUN) ||
                                (osc_state == CKGPM_OSC_BYP);
    end
  end

  // ==========================================================
  // Frequency meter
  // One measurement per stable period; main clock must stay below half clk_i
  logic [CKGPM_FREQ_COUNT_W-1:0] freq_acc;
  logic [CKGPM_FREQ_COUNT_W-1:0] freq_count;
  logic [4:0] freq_window;
  logic freq_valid;
  logic freq_busy;

  always_ff @(posedge clk_i) begin
    if (rst_i || !main_osc_stable_flag_o) begin
      freq_acc <= '0;
      freq_count <= '0;
      freq_window <= '0;
      freq_valid <= 1'b0;
      freq_busy <= 1'b0;
    end else if (!freq_valid) begin
      if (!freq_busy) begin
        if (slow_tick) begin
          freq_busy <= 1'b1;
          freq_acc <= '0;
          freq_window <= '0;
        end
      end else begin
        if (main_tick) begin
          freq_acc <= freq_acc + 1'b1;
        end
        if (slow_tick) begin
          if (freq_window == 5'(CKGPM_FREQ_WINDOW - 1)) begin
            freq_count <= freq_acc + {15'h0000, main_tick};
            freq_valid <= 1'b1;
            freq_busy <= 1'b0;
          end else begin
            freq_window <= freq_window + 1'b1;
          end
        end
      end
    end
  end

  // ==========================================================
  // PLL configuration and lock counter
  logic [CKGPM_PLL_CNT_W-1:0] pll_settle_count;
  logic [CKGPM_PLL_CNT_W-1:0] pll_timer;
  logic pll_wr;
  assign pll_wr = ckgpm_hit(wr, wb_adr_i, CKGPM_PLL_CONFIGURATION);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_in_div_o <= CKGPM_PLL_RESET[CKGPM_PLL_DIV_LSB +: CKGPM_PLL_DIV_W];
      pll_in_div_off_o <= CKGPM_PLL_RESET[CKGPM_PLL_DIV_LSB +: CKGPM_PLL_DIV_W] == '0;
      pll_settle_count <= CKGPM_PLL_RESET[CKGPM_PLL_CNT_LSB +: CKGPM_PLL_CNT_W];
      pll_range_o <= CKGPM_PLL_RESET[CKGPM_PLL_RANGE_LSB +: CKGPM_PLL_RANGE_W];
      pll_freq_factor_o <= CKGPM_PLL_RESET[CKGPM_PLL_MUL_LSB +: CKGPM_PLL_MUL_W];
      pll_active_o <= CKGPM_PLL_RESET[CKGPM_PLL_MUL_LSB +: CKGPM_PLL_MUL_W] != '0;
      usb_clock_divider_o <= CKGPM_PLL_RESET[CKGPM_PLL_USB_LSB +: CKGPM_PLL_USB_W];
    end else if (pll_wr) begin
      pll_in_div_o <= wdat[CKGPM_PLL_DIV_LSB +: CKGPM_PLL_DIV_W];
      pll_in_div_off_o <= wdat[CKGPM_PLL_DIV_LSB +: CKGPM_PLL_DIV_W] == '0;
      pll_settle_count <= wdat[CKGPM_PLL_CNT_LSB +: CKGPM_PLL_CNT_W];
      pll_range_o <= wdat[CKGPM_PLL_RANGE_LSB +: CKGPM_PLL_RANGE_W];
      pll_freq_factor_o <= wdat[CKGPM_PLL_MUL_LSB +: CKGPM_PLL_MUL_W];
      pll_active_o <= wdat[CKGPM_PLL_MUL_LSB +: CKGPM_PLL_MUL_W] != '0;
      usb_clock_divider_o <= wdat[CKGPM_PLL_USB_LSB +: CKGPM_PLL_USB_W];
    end
  end

  // A write in the cycle the count expires wins, so lock restarts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_timer <= '0;
      pll_locked_o <= 1'b0;
    end else if (pll_wr) begin
      pll_timer <= '0;
      pll_locked_o <= 1'b0;
    end else if (!pll_locked_o) begin
      if (pll_timer >= pll_settle_count) begin
        pll_locked_o <= 1'b1;
      end else if (slow_tick) begin
        pll_timer <= pll_timer + 1'b1;
      end
    end
  end

  // ==========================================================
  // Read mux and acknowledge
  // Unmapped and write-only offsets answer with zero
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (wb_adr_i)
      CKGPM_SYS_CLK_STATUS: begin
        next_rdata[CKGPM_PROC_CLK_POS] = proc_clk_en_o;
        next_rdata[CKGPM_USB_CLK_POS] = usb_port_clock_signal_en_o;
        next_rdata[CKGPM_PROG_CLK_LSB +: CKGPM_PROG_CLK_NUM] = prog_clk_en_o;
      end
      CKGPM_PERIPH_CLK_STATUS: begin
        next_rdata = periph_clk_en_o;
      end
      CKGPM_MAIN_OSC_CONTROL: begin
        next_rdata[CKGPM_OSC_ENABLE_POS] = main_osc_enable_o;
        next_rdata[CKGPM_OSC_BYPASS_POS] = osc_bypass_sel_o;
        next_rdata[CKGPM_OSC_COUNT_LSB +: CKGPM_OSC_COUNT_W] = osc_count;
      end
      CKGPM_MAIN_CLK_FREQUENCY: begin
        next_rdata[CKGPM_FREQ_COUNT_W-1:0] = freq_count;
        next_rdata[CKGPM_FREQ_VALID_POS] = freq_valid;
      end
      CKGPM_PLL_CONFIGURATION: begin
        next_rdata[CKGPM_PLL_DIV_LSB +: CKGPM_PLL_DIV_W] = pll_in_div_o;
        next_rdata[CKGPM_PLL_CNT_LSB +: CKGPM_PLL_CNT_W] = pll_settle_count;
        next_rdata[CKGPM_PLL_RANGE_LSB +: CKGPM_PLL_RANGE_W] = pll_range_o;
        next_rdata[CKGPM_PLL_MUL_LSB +: CKGPM_PLL_MUL_W] = pll_freq_factor_o;
        next_rdata[CKGPM_PLL_USB_LSB +: CKGPM_PLL_USB_W] = usb_clock_divider_o;
      end
      CKGPM_STATUS: begin
        next_rdata[CKGPM_SR_OSC_STABLE_POS] = main_osc_stable_flag_o;
        next_rdata[CKGPM_SR_LOCK_POS] = pll_locked_o;
        next_rdata[CKGPM_SR_MCK_READY_POS] = 1'b1;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      // Registered answer, one cycle after the request is taken
      wb_ack_o <= access;
      wb_dat_o <= (access && !wb_we_i) ? next_rdata : 32'h0000_0000;
    end
  end

endmodule : ckgpm_top

/* File: tb/ckgpm_props.sv */
`timescale 1ns/100ps
// ==========================================================
// Bus handshake and clock control checks
module ckgpm_props
  import ckgpm_pkg::*;
#(
  parameter logic [31:0] PERIPH_IMPL = CKGPM_PERIPH_IMPL_DEFAULT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Observed controls
  input wire logic proc_clk_en_o,
  input wire logic usb_port_clock_signal_en_o,
  input wire logic [31:0] periph_clk_en_o,
  input wire logic main_osc_stable_flag_o,
  input wire logic [7:0] pll_in_div_o,
  input wire logic pll_in_div_off_o,
  input wire logic [10:0] pll_freq_factor_o,
  input wire logic pll_active_o,
  input wire logic pll_locked_o
);
  logic take;
  logic wr;
  // wr looks at lane 0 only; chk_pll_active checks lanes 2 and 3 through take instead
  assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = take & wb_we_i & wb_sel_i[0];

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_ack_follows_req: assert property (take |=> wb_ack_o)
    else $error("no ack after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_unasked: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_proc_disable: assert property (
    wr && wb_adr_i == CKGPM_SYS_CLK_DISABLE && wb_dat_i[0] |-> ##[1:2] !proc_clk_en_o)
    else $error("processor clock not stopped");
  chk_usb_disable: assert property (
    wr && wb_adr_i == CKGPM_SYS_CLK_DISABLE && wb_dat_i[7] |-> ##[1:2] !usb_port_clock_signal_en_o)
    else $error("usb clock not stopped");
  chk_proc_enable: assert property (
    wr && wb_adr_i == CKGPM_SYS_CLK_ENABLE && wb_dat_i[0] |-> ##[1:2] proc_clk_en_o)
    else $error("processor clock not started");
  chk_periph_impl: assert property ((periph_clk_en_o & ~PERIPH_IMPL) == 32'h0)
    else $error("unimplemented peripheral clock on");
  chk_lock_restart: assert property (
    wr && wb_adr_i == CKGPM_PLL_CONFIGURATION |=> !pll_locked_o)
    else $error("lock not cleared by pll write");
  chk_bypass_stable: assert property (
    wr && wb_adr_i == CKGPM_MAIN_OSC_CONTROL && wb_dat_i[1:0] == 2'h2
    |-> ##[1:3] main_osc_stable_flag_o) else $error("bypass not stable at once");
  chk_osc_clear: assert property (
    wr && wb_adr_i == CKGPM_MAIN_OSC_CONTROL && wb_dat_i[1:0] == 2'h0
    |-> ##[1:3] !main_osc_stable_flag_o) else $error("stable flag not cleared");
  chk_pll_active: assert property (
    take && wb_we_i && wb_adr_i == CKGPM_PLL_CONFIGURATION && wb_sel_i[3:2] == 2'h3
    |=> pll_freq_factor_o == $past(wb_dat_i[26:16]) &&
      pll_active_o == ($past(wb_dat_i[26:16]) != 11'h0))
    else $error("pll factor or active wrong after write");
  chk_div_off: assert property (
    wr && wb_adr_i == CKGPM_PLL_CONFIGURATION
    |=> pll_in_div_o == $past(wb_dat_i[7:0]) &&
      pll_in_div_off_o == ($past(wb_dat_i[7:0]) == 8'h0))
    else $error("divider value or off flag wrong after write");

  cover property (wr && wb_adr_i == CKGPM_PLL_CONFIGURATION);
  cover property ($rose(pll_locked_o));
  cover property ($rose(main_osc_stable_flag_o));
endmodule : ckgpm_props

bind ckgpm_top ckgpm_props #(.PERIPH_IMPL(PERIPH_IMPL)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .proc_clk_en_o(proc_clk_en_o),
  .usb_port_clock_signal_en_o(usb_port_clock_signal_en_o),
  .periph_clk_en_o(periph_clk_en_o), .main_osc_stable_flag_o(main_osc_stable_flag_o),
  .pll_in_div_o(pll_in_div_o), .pll_in_div_off_o(pll_in_div_off_o),
  .pll_freq_factor_o(pll_freq_factor_o), .pll_active_o(pll_active_o),
  .pll_locked_o(pll_locked_o)
);

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench
  import ckgpm_pkg::*;
();
  // Upper half unimplemented, so stray peripheral bits can be seen
  localparam logic [31:0] IMPL = 32'h0000_fffc;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic slow_clk_i = 1'b0;
  logic main_clk_i = 1'b0;
  logic [31:0] wb_dat_o, periph_clk_en_o, rd;
  logic wb_ack_o, proc_clk_en_o, usb_port_clock_signal_en_o, main_osc_enable_o;
  logic osc_bypass_sel_o, main_osc_stable_flag_o, pll_in_div_off_o, pll_active_o;
  logic pll_locked_o;
  logic [2:0] prog_clk_en_o;
  logic [7:0] pll_in_div_o;
  logic [7:0] tick = 8'h00;
  logic [10:0] pll_freq_factor_o;
  logic [1:0] pll_range_o, usb_clock_divider_o;
  logic [72:0] rows [17];
  int errors = 0;
  int n_compared = 0;
  int n;

  ckgpm_top #(.PERIPH_IMPL(IMPL)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .slow_clk_i(slow_clk_i),
    .main_clk_i(main_clk_i), .proc_clk_en_o(proc_clk_en_o),
    .usb_port_clock_signal_en_o(usb_port_clock_signal_en_o),
    .prog_clk_en_o(prog_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
    .main_osc_enable_o(main_osc_enable_o), .osc_bypass_sel_o(osc_bypass_sel_o),
    .main_osc_stable_flag_o(main_osc_stable_flag_o), .pll_in_div_o(pll_in_div_o),
    .pll_in_div_off_o(pll_in_div_off_o), .pll_freq_factor_o(pll_freq_factor_o),
    .pll_active_o(pll_active_o), .pll_range_o(pll_range_o),
    .usb_clock_divider_o(usb_clock_divider_o), .pll_locked_o(pll_locked_o)
  );

  // ==========================================================
  // Clocks: slow = clk/8, main = clk/4, rising edges never coincide
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    tick <= tick + 8'h01;
    slow_clk_i <= ~tick[2];
    main_clk_i <= tick[1];
  end

  // ==========================================================
  // Tasks
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    check("ack", {31'h0, wb_ack_o}, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task final_report;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rows = '{
      {1'b1, CKGPM_SYS_CLK_ENABLE, 32'h0000_0781, 32'h0},
      {1'b0, CKGPM_SYS_CLK_STATUS, 32'h0, 32'h0000_0781},
      {1'b1, CKGPM_SYS_CLK_DISABLE, 32'h0000_0201, 32'h0},
      {1'b0, CKGPM_SYS_CLK_STATUS, 32'h0, 32'h0000_0580},
      {1'b1, CKGPM_SYS_CLK_DISABLE, 32'h0000_0080, 32'h0},
      {1'b0, CKGPM_SYS_CLK_STATUS, 32'h0, 32'h0000_0500},
      {1'b1, CKGPM_SYS_CLK_STATUS, 32'hffff_ffff, 32'h0},
      {1'b0, CKGPM_SYS_CLK_STATUS, 32'h0, 32'h0000_0500},
      {1'b1, CKGPM_PERIPH_CLK_ENABLE, 32'hffff_ffff, 32'h0},
      {1'b0, CKGPM_PERIPH_CLK_STATUS, 32'h0, 32'h0000_fffc},
      {1'b1, CKGPM_PERIPH_CLK_DISABLE, 32'h0000_0110, 32'h0},
      {1'b0, CKGPM_PERIPH_CLK_STATUS, 32'h0, 32'h0000_feec},
      {1'b0, CKGPM_SYS_CLK_ENABLE, 32'h0, 32'h0},
      {1'b0, 8'h0c, 32'h0, 32'h0},
      {1'b1, CKGPM_PLL_CONFIGURATION, 32'h1123_4105, 32'h0},
      {1'b0, CKGPM_PLL_CONFIGURATION, 32'h0, 32'h1123_4105},
      {1'b0, CKGPM_MAIN_OSC_CONTROL, 32'h0, 32'h0}};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wb_xfer(rows[i][72], rows[i][71:64], rows[i][63:32]);
      if (!rows[i][72]) check("table read", rd, rows[i][31:0]);
    end
    check("periph gates", periph_clk_en_o, 32'h0000_feec);
    check("sys gates",
          {28'h0, proc_clk_en_o, usb_port_clock_signal_en_o, prog_clk_en_o}, 32'h5);
    check("pll fields",
          {pll_in_div_o, pll_range_o, pll_freq_factor_o, usb_clock_divider_o, 9'h0},
          {8'h05, 2'h1, 11'h123, 2'h1, 9'h0});
    for (int c = 0; c < 4; c++) begin
      wb_xfer(1'b1, CKGPM_PLL_CONFIGURATION, {2'h0, 2'(c), 1'b0, 11'(c), 8'h00, 8'(c)});
      @(negedge clk_i);
      check("pll codes",
            {28'h0, usb_clock_divider_o, pll_in_div_off_o, pll_active_o},
            {28'h0, 2'(c), c == 0, c != 0});
    end
    // Settle count of three slow ticks, timed from the ack
    wb_xfer(1'b1, CKGPM_PLL_CONFIGURATION, 32'h0000_0301);
    n = 0;
    while (pll_locked_o !== 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    check("lock delay", 32'(n >= 15 && n <= 36), 32'h1);
    wb_xfer(1'b0, CKGPM_STATUS, 32'h0);
    check("status lock", rd & 32'h0000_000c, 32'h0000_000c);
    wb_xfer(1'b1, CKGPM_MAIN_OSC_CONTROL, 32'h0000_0201);
    n = 0;
    while (main_osc_stable_flag_o !== 1'b1 && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    check("osc delay", 32'(n >= 118 && n <= 140), 32'h1);
    wb_xfer(1'b0, CKGPM_MAIN_OSC_CONTROL, 32'h0);
    check("osc control", {rd[30:0], main_osc_enable_o}, 32'h0000_0403);
    n = 0;
    do begin
      wb_xfer(1'b0, CKGPM_MAIN_CLK_FREQUENCY, 32'h0);
      n++;
    end while (rd[16] !== 1'b1 && n < 100);
    check("freq", rd, 32'h0001_0020);
    wb_xfer(1'b1, CKGPM_MAIN_OSC_CONTROL, 32'h0);
    repeat (4) @(posedge clk_i);
    check("osc off", {31'h0, main_osc_stable_flag_o}, 32'h0);
    wb_xfer(1'b0, CKGPM_MAIN_CLK_FREQUENCY, 32'h0);
    check("freq invalid", {31'h0, rd[16]}, 32'h0);
    wb_xfer(1'b1, CKGPM_MAIN_OSC_CONTROL, 32'h0000_0002);
    repeat (4) @(posedge clk_i);
    check("bypass",
          {29'h0, osc_bypass_sel_o, main_osc_enable_o, main_osc_stable_flag_o}, 32'h5);
    // Second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check("reset outs",
          {29'h0, osc_bypass_sel_o, main_osc_stable_flag_o, pll_locked_o}, 32'h0);
    wb_xfer(1'b0, CKGPM_SYS_CLK_STATUS, 32'h0);
    check("reset sys", rd, CKGPM_SYS_CLK_RESET);
    wb_xfer(1'b0, CKGPM_PERIPH_CLK_STATUS, 32'h0);
    check("reset periph", rd, 32'h0);
    wb_xfer(1'b0, CKGPM_PLL_CONFIGURATION, 32'h0);
    check("reset pll", rd, CKGPM_PLL_RESET);
    wb_xfer(1'b0, CKGPM_MAIN_OSC_CONTROL, 32'h0);
    check("reset osc", rd, CKGPM_MOR_RESET);
    final_report();
  end
endmodule : testbench
